// file: hdl/event_aggregator.sv
// event_aggregator: status, multicast and counted stages on one dispatcher
// assumes: transport bus sources/sinks use valid/ready in CORE_CLK domain
`timescale 1ns/1ps
module event_aggregator #(
   parameter int EVT_W = event_aggregator_pkg::EVT_W,
   parameter int STAT_IDX_W = event_aggregator_pkg::STAT_IDX_W,
   parameter int CNT_W = event_aggregator_pkg::CNT_W
) (
   input wire logic CORE_CLK,
   input wire logic RST_B,
   input wire logic CLK_EN,
   input wire logic IN_VALID,
   output logic IN_READY,
   input wire logic [EVT_W-1:0] IN_EVENT,
   output logic OUT_VALID,
   input wire logic OUT_READY,
   output logic [EVT_W-1:0] OUT_EVENT,
   input wire logic MC_SPLIT_EN,
   input wire logic [EVT_W-1:0] MC_EVT_A,
   input wire logic [EVT_W-1:0] MC_EVT_B,
   input wire logic [EVT_W-1:0] CNT_UP_EVT,
   input wire logic [EVT_W-1:0] CNT_DN_EVT,
   input wire logic CNT_DEC,
   output logic CNT_DEC_READY,
   output logic [CNT_W-1:0] COUNT_VALUE,
   input wire logic [(1<<STAT_IDX_W)-1:0] STAT_CLR,
   output logic [(1<<STAT_IDX_W)-1:0] INTR
);

   localparam int NSTAT = 1 << STAT_IDX_W;
   localparam int SLSB = EVT_W - event_aggregator_pkg::STAGE_W;

   initial begin
      if (EVT_W < STAT_IDX_W + event_aggregator_pkg::STAGE_W) begin
         $error("event_aggregator: EVT_W too small for stage and index");
      end
      if (CNT_W < 2) begin
         $error("event_aggregator: CNT_W must be at least 2");
      end
   end

   typedef enum logic [1:0] {
      MC_IDLE,
      MC_TWO,
      MC_ONE
   } mc_state_t;

   typedef enum logic [1:0] {
      SRC_NONE,
      SRC_MC,
      SRC_CNT,
      SRC_EXT
   } src_t;

   function automatic event_aggregator_pkg::stage_t dest_of(
      input logic [EVT_W-1:0] evt
   );
      dest_of = event_aggregator_pkg::stage_t'(evt[EVT_W-1:SLSB]);
   endfunction : dest_of

   // -------------------------------------------------------------
   // dispatcher: internal outputs drain ahead of new bus input
   // -------------------------------------------------------------
   mc_state_t mc_state_ff;
   mc_state_t nxt_mc_state;
   logic [EVT_W-1:0] mc_evt_ff;
   logic [EVT_W-1:0] nxt_mc_evt;
   logic mc_valid;
   logic cnt_slot_valid;
   logic cnt_slot_in_ready;
   logic [EVT_W-1:0] cnt_slot_evt;
   logic cnt_push;
   logic [EVT_W-1:0] cnt_push_evt;
   logic out_in_ready;
   logic [CNT_W-1:0] count_ff;
   logic [CNT_W-1:0] nxt_count;
   logic [NSTAT-1:0] status_ff;
   logic [NSTAT-1:0] nxt_status;
   src_t sel_src;
   logic sel_valid;
   logic [EVT_W-1:0] sel_evt;
   event_aggregator_pkg::stage_t sel_dest;
   logic can_take;
   logic take;
   logic stat_take;
   logic mc_take;
   logic cnt_take;
   logic out_take;
   logic mc_out_take;
   logic cnt_dec_fire;
   logic [STAT_IDX_W-1:0] stat_idx;

   assign mc_valid = (mc_state_ff != MC_IDLE);

   // counted output goes first: it never feeds multicast, so a copy aimed
   // at the counted stage cannot wait forever behind a full counted slot
   always_comb begin
      sel_src = SRC_NONE;
      sel_evt = IN_EVENT;
      if (cnt_slot_valid) begin
         sel_src = SRC_CNT;
         sel_evt = cnt_slot_evt;
      end else if (mc_valid) begin
         sel_src = SRC_MC;
         sel_evt = mc_evt_ff;
      end else if (IN_VALID) begin
         sel_src = SRC_EXT;
      end
   end

   assign sel_valid = (sel_src != SRC_NONE);
   assign sel_dest = dest_of(sel_evt);

   // a stage takes only while its own output side has room
   always_comb begin
      unique case (sel_dest)
         event_aggregator_pkg::STG_STATUS: can_take = 1'b1;
         event_aggregator_pkg::STG_MULTI: can_take = ~mc_valid;
         event_aggregator_pkg::STG_COUNT:
            can_take = cnt_slot_in_ready & (count_ff != '1);
         event_aggregator_pkg::STG_BUS: can_take = out_in_ready;
      endcase
   end

   assign take = CLK_EN & sel_valid & can_take;
   assign stat_take = take & (sel_dest == event_aggregator_pkg::STG_STATUS);
   assign mc_take = take & (sel_dest == event_aggregator_pkg::STG_MULTI);
   assign cnt_take = take & (sel_dest == event_aggregator_pkg::STG_COUNT);
   assign out_take = take & (sel_dest == event_aggregator_pkg::STG_BUS);
   assign mc_out_take = take & (sel_src == SRC_MC);
   assign IN_READY = CLK_EN & ~mc_valid & ~cnt_slot_valid
                     & can_take;

   // -------------------------------------------------------------
   // status stage
   // -------------------------------------------------------------
   assign stat_idx = sel_evt[event_aggregator_pkg::STAT_IDX_LSB +: STAT_IDX_W];

   // set wins over a clear in the same cycle
   always_comb begin
      nxt_status = status_ff & ~STAT_CLR;
      if (stat_take) begin
         nxt_status[stat_idx] = 1'b1;
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         status_ff <= {NSTAT{event_aggregator_pkg::STAT_RST}};
      end else if (CLK_EN) begin
         status_ff <= nxt_status;
      end
   end

   assign INTR = status_ff;

   // -------------------------------------------------------------
   // multicast stage
   // -------------------------------------------------------------
   // outputs re-enter the dispatcher; a self-routed copy would stall here
   always_comb begin
      nxt_mc_state = mc_state_ff;
      nxt_mc_evt = mc_evt_ff;
      unique case (mc_state_ff)
         MC_IDLE: begin
            if (mc_take) begin
               nxt_mc_state = MC_SPLIT_EN ? MC_TWO : MC_ONE;
               nxt_mc_evt = MC_EVT_A;
            end
         end
         MC_TWO: begin
            if (mc_out_take) begin
               nxt_mc_state = MC_ONE;
               nxt_mc_evt = MC_EVT_B;
            end
         end
         MC_ONE: begin
            if (mc_out_take) begin
               nxt_mc_state = MC_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         mc_state_ff <= MC_IDLE;
         mc_evt_ff <= '0;
      end else if (CLK_EN) begin
         mc_state_ff <= nxt_mc_state;
         mc_evt_ff <= nxt_mc_evt;
      end
   end

   // -------------------------------------------------------------
   // counted stage
   // -------------------------------------------------------------
   // output ids are trusted not to target multicast, so no loop forms
   assign CNT_DEC_READY = CLK_EN & cnt_slot_in_ready
                          & (count_ff != '0) & ~cnt_take;
   assign cnt_dec_fire = CNT_DEC & CNT_DEC_READY;

   always_comb begin
      nxt_count = count_ff + CNT_W'(cnt_take) - CNT_W'(cnt_dec_fire);
      cnt_push = (count_ff == '0) != (nxt_count == '0);
      cnt_push_evt = (count_ff == '0) ? CNT_UP_EVT : CNT_DN_EVT;
   end

   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         count_ff <= event_aggregator_pkg::CNT_RST;
      end else if (CLK_EN) begin
         count_ff <= nxt_count;
      end
   end

   assign COUNT_VALUE = count_ff;

   event_slot #(
      .W(EVT_W)
   ) u_cnt_slot (
      .clk(CORE_CLK),
      .rst_b(RST_B),
      .en(CLK_EN),
      .in_valid(cnt_push),
      .in_ready(cnt_slot_in_ready),
      .in_data(cnt_push_evt),
      .out_valid(cnt_slot_valid),
      .out_ready(take & (sel_src == SRC_CNT)),
      .out_data(cnt_slot_evt)
   );

   // -------------------------------------------------------------
   // transport bus output
   // -------------------------------------------------------------
   event_slot #(
      .W(EVT_W)
   ) u_out_slot (
      .clk(CORE_CLK),
      .rst_b(RST_B),
      .en(CLK_EN),
      .in_valid(out_take),
      .in_ready(out_in_ready),
      .in_data(sel_evt),
      .out_valid(OUT_VALID),
      .out_ready(OUT_READY & CLK_EN),
      .out_data(OUT_EVENT)
   );

   // -------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------
   sequence s_mc_in;
      mc_take && MC_SPLIT_EN;
   endsequence

   sequence s_mc_first;
      mc_valid && mc_evt_ff == MC_EVT_A && mc_state_ff == MC_TWO;
   endsequence

   property p_stat_set;
      @(posedge CORE_CLK) disable iff (!RST_B)
      stat_take |=> INTR[$past(stat_idx)];
   endproperty
   a_stat_set: assert property (p_stat_set)
      else $error("status bit not set by event");

   property p_intr_level;
      @(posedge CORE_CLK) disable iff (!RST_B)
      INTR[0] && !STAT_CLR[0] |=> INTR[0];
   endproperty
   a_intr_level: assert property (p_intr_level)
      else $error("interrupt level dropped without clear");

   property p_mc_split;
      @(posedge CORE_CLK) disable iff (!RST_B)
      s_mc_in |=> s_mc_first;
   endproperty
   a_mc_split: assert property (p_mc_split)
      else $error("multicast did not hold first of two events");

   property p_mc_second;
      @(posedge CORE_CLK) disable iff (!RST_B)
      mc_state_ff == MC_TWO && mc_out_take
         |=> mc_valid && mc_evt_ff == MC_EVT_B;
   endproperty
   a_mc_second: assert property (p_mc_second)
      else $error("multicast second event missing");

   property p_cnt_inc;
      @(posedge CORE_CLK) disable iff (!RST_B)
      cnt_take |=> COUNT_VALUE == $past(COUNT_VALUE) + CNT_W'(1);
   endproperty
   a_cnt_inc: assert property (p_cnt_inc)
      else $error("count did not advance by one");

   property p_cnt_up;
      @(posedge CORE_CLK) disable iff (!RST_B)
      COUNT_VALUE == '0 ##1 COUNT_VALUE != '0
         |-> cnt_slot_valid && cnt_slot_evt == CNT_UP_EVT;
   endproperty
   a_cnt_up: assert property (p_cnt_up)
      else $error("no event on zero to non-zero");

   property p_cnt_dn;
      @(posedge CORE_CLK) disable iff (!RST_B)
      COUNT_VALUE != '0 ##1 COUNT_VALUE == '0
         |-> cnt_slot_valid && cnt_slot_evt == CNT_DN_EVT;
   endproperty
   a_cnt_dn: assert property (p_cnt_dn)
      else $error("no event on return to zero");

   property p_cnt_block;
      @(posedge CORE_CLK) disable iff (!RST_B)
      cnt_slot_valid |=> $stable(COUNT_VALUE);
   endproperty
   a_cnt_block: assert property (p_cnt_block)
      else $error("counted stage took input while output blocked");

   property p_reroute;
      @(posedge CORE_CLK) disable iff (!RST_B)
      out_take && sel_src != SRC_EXT |=> OUT_VALID
         && OUT_EVENT == $past(sel_evt);
   endproperty
   a_reroute: assert property (p_reroute)
      else $error("stage output not routed as bus event");

   property p_out_hold;
      @(posedge CORE_CLK) disable iff (!RST_B)
      OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_EVENT);
   endproperty
   a_out_hold: assert property (p_out_hold)
      else $error("bus output event dropped under back-pressure");

endmodule : event_aggregator

// file: hdl/event_aggregator_pkg.sv
// event aggregation fabric: shared widths, stage codes and reset values
// assumes: one clock domain, event ids carry their stage code in top bits
package event_aggregator_pkg;

   // -------------------------------------------------------------
   // event layout
   // -------------------------------------------------------------
   localparam int EVT_W = 8;
   localparam int STAGE_W = 2;
   localparam int STAGE_LSB = EVT_W - STAGE_W;
   localparam int STAT_IDX_W = 4;
   localparam int STAT_IDX_LSB = 0;
   localparam int CNT_W = 16;

   // -------------------------------------------------------------
   // reset values
   // -------------------------------------------------------------
   localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
   localparam logic STAT_RST = 1'h0;

   // stage that an event id is routed to, from its top bits
   typedef enum logic [STAGE_W-1:0] {
      STG_STATUS,
      STG_MULTI,
      STG_COUNT,
      STG_BUS
   } stage_t;

endpackage : event_aggregator_pkg

// file: hdl/event_slot.sv
// event_slot: one-entry holding register with valid/ready on both sides
// assumes: upstream holds data stable while in_valid is high and not taken
`timescale 1ns/1ps
module event_slot #(
   parameter int W = 8
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic en,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);

   logic full_ff;
   logic nxt_full;
   logic [W-1:0] data_ff;
   logic [W-1:0] nxt_data;

   initial begin
      if (W < 1) begin
         $error("event_slot: W must be at least 1");
      end
   end

   // no pass-through: a held event blocks new input until it leaves
   assign in_ready = en & ~full_ff;
   assign out_valid = full_ff;
   assign out_data = data_ff;

   always_comb begin
      nxt_full = full_ff;
      nxt_data = data_ff;
      if (full_ff && out_ready) begin
         nxt_full = 1'b0;
      end
      if (in_valid && !full_ff) begin
         nxt_full = 1'b1;
         nxt_data = in_data;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         full_ff <= 1'b0;
         data_ff <= '0;
      end else if (en) begin
         full_ff <= nxt_full;
         data_ff <= nxt_data;
      end
   end

endmodule : event_slot

// file: verif/event_aggregation_fabric_bench.sv
// event_aggregation_fabric_bench: directed scenarios for event_aggregator
// assumes: event_sink stands in for the transport bus destination
`timescale 1ns/1ps
module event_aggregation_fabric_bench;
   localparam int W = event_aggregator_pkg::EVT_W;
   logic CORE_CLK, RST_B, CLK_EN, IN_VALID, IN_READY, OUT_VALID, OUT_READY;
   logic MC_SPLIT_EN, CNT_DEC, CNT_DEC_READY, STALL;
   logic [W-1:0] IN_EVENT, OUT_EVENT, MC_EVT_A, MC_EVT_B;
   logic [W-1:0] CNT_UP_EVT, CNT_DN_EVT;
   logic [15:0] COUNT_VALUE, STAT_CLR, INTR;
   int num_errors = 0;
   int check_count = 0;

   event_aggregator DUT (.CORE_CLK(CORE_CLK), .RST_B(RST_B),
      .CLK_EN(CLK_EN), .IN_VALID(IN_VALID), .IN_READY(IN_READY),
      .IN_EVENT(IN_EVENT), .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY),
      .OUT_EVENT(OUT_EVENT), .MC_SPLIT_EN(MC_SPLIT_EN),
      .MC_EVT_A(MC_EVT_A), .MC_EVT_B(MC_EVT_B), .CNT_UP_EVT(CNT_UP_EVT),
      .CNT_DN_EVT(CNT_DN_EVT), .CNT_DEC(CNT_DEC),
      .CNT_DEC_READY(CNT_DEC_READY), .COUNT_VALUE(COUNT_VALUE),
      .STAT_CLR(STAT_CLR), .INTR(INTR));
   event_sink far_end (.clk(CORE_CLK), .rst_b(RST_B), .stall(STALL),
      .out_valid(OUT_VALID), .out_event(OUT_EVENT), .out_ready(OUT_READY));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic finish_test();
      if (num_errors == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                      input string what);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic chk_evt(input logic [W-1:0] exp);
      int n;
      n = 0;
      while (far_end.got.size() == 0 && n < 50) begin
         @(negedge CORE_CLK);
         n++;
      end
      if (far_end.got.size() == 0) begin
         chk(16'h0100, {8'h00, exp}, "missing event");
      end else begin
         chk({8'h00, far_end.got.pop_front()}, {8'h00, exp}, "event");
      end
   endtask : chk_evt

   // hold the request until ready is seen, then drop it after the edge
   task automatic wait_taken(input bit dec);
      int n;
      n = 0;
      do begin
         @(negedge CORE_CLK);
         n++;
      end while ((dec ? CNT_DEC_READY : IN_READY) !== 1'b1 && n < 50);
      chk(16'h0001, {15'h0000, dec ? CNT_DEC_READY : IN_READY}, "ready");
      @(posedge CORE_CLK);
      if (dec) CNT_DEC <= 1'b0;
      else IN_VALID <= 1'b0;
   endtask : wait_taken

   task automatic send(input logic [W-1:0] e);
      @(posedge CORE_CLK);
      IN_EVENT <= e;
      IN_VALID <= 1'b1;
      wait_taken(1'b0);
   endtask : send

   task automatic dec();
      @(posedge CORE_CLK);
      CNT_DEC <= 1'b1;
      wait_taken(1'b1);
   endtask : dec

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_status();
      send(8'h05);
      @(negedge CORE_CLK);
      chk(INTR, 16'h0020, "status set");
      repeat (3) @(negedge CORE_CLK);
      chk(INTR, 16'h0020, "status level");
      @(posedge CORE_CLK);
      STAT_CLR <= 16'h0020;
      @(posedge CORE_CLK);
      STAT_CLR <= 16'h0000;
      @(negedge CORE_CLK);
      chk(INTR, 16'h0000, "status clear");
   endtask : t_status

   task automatic t_backpressure();
      @(posedge CORE_CLK);
      STALL <= 1'b1;
      send(8'hC5);
      @(posedge CORE_CLK);
      IN_EVENT <= 8'hC6;
      IN_VALID <= 1'b1;
      repeat (4) @(negedge CORE_CLK);
      chk(IN_READY, 16'h0000, "refuse when blocked");
      chk({15'h0000, OUT_VALID}, 16'h0001, "held valid");
      chk(OUT_EVENT, 16'h00C5, "held event");
      @(posedge CORE_CLK);
      STALL <= 1'b0;
      wait_taken(1'b0);
      chk_evt(8'hC5);
      chk_evt(8'hC6);
   endtask : t_backpressure

   task automatic t_multicast();
      send(8'h40);
      chk_evt(8'hC2);
      chk(INTR, 16'h0008, "split A to status");
      @(posedge CORE_CLK);
      MC_SPLIT_EN <= 1'b0;
      STAT_CLR <= 16'h0008;
      @(posedge CORE_CLK);
      STAT_CLR <= 16'h0000;
      send(8'h41);
      repeat (6) @(negedge CORE_CLK);
      chk(INTR, 16'h0008, "single A to status");
      chk(far_end.got.size(), 16'h0000, "single output");
   endtask : t_multicast

   task automatic t_counted();
      send(8'h80);
      @(negedge CORE_CLK);
      chk(COUNT_VALUE, 16'h0001, "count up");
      chk_evt(8'hC3);
      send(8'h81);
      @(negedge CORE_CLK);
      chk(COUNT_VALUE, 16'h0002, "count second");
      dec();
      @(negedge CORE_CLK);
      chk(COUNT_VALUE, 16'h0001, "count down");
      dec();
      @(negedge CORE_CLK);
      chk(COUNT_VALUE, 16'h0000, "count zero");
      chk_evt(8'hC4);
      repeat (6) @(negedge CORE_CLK);
      chk(far_end.got.size(), 16'h0000, "no extra event");
   endtask : t_counted

   // both copies into the counted stage: must not lock up
   task automatic t_split_count();
      @(posedge CORE_CLK);
      MC_SPLIT_EN <= 1'b1;
      MC_EVT_A <= 8'h80;
      MC_EVT_B <= 8'h81;
      send(8'h40);
      chk_evt(8'hC3);
      @(negedge CORE_CLK);
      chk(COUNT_VALUE, 16'h0002, "split into count");
      dec();
      dec();
      chk_evt(8'hC4);
      chk(COUNT_VALUE, 16'h0000, "split count drained");
   endtask : t_split_count

   task automatic t_freeze();
      @(posedge CORE_CLK);
      CLK_EN <= 1'b0;
      STAT_CLR <= 16'h0008;
      @(negedge CORE_CLK);
      chk(IN_READY, 16'h0000, "frozen ready");
      chk(CNT_DEC_READY, 16'h0000, "frozen dec ready");
      @(posedge CORE_CLK);
      CLK_EN <= 1'b1;
      STAT_CLR <= 16'h0000;
      @(negedge CORE_CLK);
      chk(INTR, 16'h0008, "frozen status kept");
   endtask : t_freeze

   // ------------------------------------------------------------
   // clock, watchdog, main sequence
   // ------------------------------------------------------------
   initial begin
      CORE_CLK = 1'b0;
      forever #20 CORE_CLK = ~CORE_CLK;
   end

   // whole run is under two hundred cycles; 5000 leaves ample margin
   initial begin
      #(40 * 5000);
      num_errors++;
      finish_test();
   end

   initial begin
      RST_B = 1'b0;
      CLK_EN = 1'b1;
      IN_VALID = 1'b0;
      IN_EVENT = 8'h00;
      MC_SPLIT_EN = 1'b1;
      MC_EVT_A = 8'h03;
      MC_EVT_B = 8'hC2;
      CNT_UP_EVT = 8'hC3;
      CNT_DN_EVT = 8'hC4;
      CNT_DEC = 1'b0;
      STAT_CLR = 16'h0000;
      STALL = 1'b0;
      repeat (2) @(posedge CORE_CLK);
      RST_B <= 1'b1;
      @(negedge CORE_CLK);
      chk({15'h0000, OUT_VALID}, 16'h0000, "reset valid");
      chk(COUNT_VALUE, 16'h0000, "reset count");
      t_status();
      t_backpressure();
      t_multicast();
      t_counted();
      t_split_count();
      t_freeze();
      finish_test();
   end
endmodule : event_aggregation_fabric_bench

// file: verif/event_sink.sv
// event_sink: far-side consumer of transport bus output events
// assumes: valid/ready sampled on the rising clock edge, stall from bench
`timescale 1ns/1ps
module event_sink (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic stall,
   input wire logic out_valid,
   input wire logic [event_aggregator_pkg::EVT_W-1:0] out_event,
   output logic out_ready
);
   logic [event_aggregator_pkg::EVT_W-1:0] got[$];
   logic nxt_ready;
   logic ready_ff;

   // registered ready: a stall only bites one edge later, like a real sink
   always_comb nxt_ready = !stall;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ready_ff <= 1'b0;
      end else begin
         ready_ff <= nxt_ready;
      end
   end
   assign out_ready = ready_ff;

   always @(posedge clk) begin
      if (rst_b && out_valid && out_ready) begin
         got.push_back(out_event);
      end
   end
endmodule : event_sink
